// File: hw/cal_timer.sv
module cal_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Time base and calendar
  input wire logic sec_tick,
  input wire logic [run_timer_pkg::TOD_W-1:0] cal_tod,
  input wire logic [2:0] weekday,
  // Settings
  input wire logic [run_timer_pkg::MODE_W-1:0] mode,
  input wire logic [run_timer_pkg::TOD_W-1:0] on_tod,
  input wire logic [run_timer_pkg::TOD_W-1:0] off_tod,
  // Forcing and restore
  input wire logic force_we,
  input wire logic force_val,
  input wire logic restore_we,
  input wire logic restore_val,
  // Timer output
  output logic out_q
);
  import run_timer_pkg::*;

  // ****************************************
  // Weekday gating
  // ****************************************
  // True when the mode lets this weekday switch
  function automatic logic day_enabled(input logic [3:0] m, input logic [2:0] d);
    logic ok;
    ok = 1'b0;
    if (m == MODE_DAILY)
    begin
      ok = 1'b1;
    end
    else if (m >= MODE_MON && m <= MODE_SUN)
    begin
      ok = (m - MODE_MON) == {1'b0, d};
    end
    else if (m == MODE_WEEKDAYS)
    begin
      ok = (d != DAY_SAT) && (d != DAY_SUN);
    end
    else if (m == MODE_MON_TO_SAT)
    begin
      ok = (d != DAY_SUN);
    end
    else if (m == MODE_WEEKEND)
    begin
      ok = (d == DAY_SAT) || (d == DAY_SUN);
    end
    return ok;
  endfunction

  // Codes above the weekend mode behave as not in use
  wire in_use = (mode != MODE_NONE) && (mode <= MODE_WEEKEND);
  wire day_ok = day_enabled(mode, weekday);
  wire hit_on = sec_tick & day_ok & (cal_tod == on_tod);
  wire hit_off = sec_tick & day_ok & (cal_tod == off_tod);

  // ****************************************
  // Output state
  // ****************************************
  // Off wins when on and off times are equal
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_q <= 1'b0;
    end
    else if (!in_use)
    begin
      out_q <= 1'b0;
    end
    else if (force_we)
    begin
      out_q <= force_val;
    end
    else if (restore_we)
    begin
      out_q <= restore_val;
    end
    else if (hit_off)
    begin
      out_q <= 1'b0;
    end
    else if (hit_on)
    begin
      out_q <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  idle_zero_a: assert property (!in_use |=> !out_q)
    else $error("idle timer output not low");
  force_val_a: assert property (force_we && in_use |=> out_q == $past(force_val))
    else $error("forced value not taken");
  on_time_a: assert property (hit_on && !hit_off && in_use && !force_we && !restore_we |=> out_q)
    else $error("timer did not switch on");
  day_gate_a: assert property (sec_tick && in_use && !day_ok && !force_we && !restore_we |=> $stable(out_q))
    else $error("timer switched on a gated day");

endmodule

// File: hw/run_hour_timers.sv
// Contract
// - Accumulate active time in ten-second steps
// - Hours part reaches 876000
// - Seconds 0..3599, carry into hours
// - Rise counts activation, stamps start
// - Fall stamps stop date and time
// - Status shows run or stop
// - Software selects signal; none stops counting
// - Hours, seconds, count readable and writable
// - Four independent calendar timers
// - On and off times per timer
// - Twelve modes per timer
// - Not in use: output held zero
// - Daily mode switches every day
// - Single weekday mode switches that day
// - Weekdays mode skips Saturday and Sunday
// - Monday to Saturday mode skips Sunday
// - Weekend mode switches Saturday and Sunday
// - Status write forces output of a timer in use
// - Force lasts until next opposite act
// - Idle timers ignore status writes
// - Timer status saved and restored
// - Timer outputs offered to other logic
//
// Register access over APB and the register addresses were decided locally.
module run_hour_timers
#(
  parameter int SEC_CYCLES = run_timer_pkg::SEC_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [run_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [run_timer_pkg::DATA_W-1:0] pwdata,
  output logic [run_timer_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Candidate supervised signals
  input wire logic [run_timer_pkg::NUM_PHYS-1:0] phys_in,
  input wire logic [run_timer_pkg::NUM_VIN-1:0] virt_in,
  input wire logic [run_timer_pkg::NUM_MTX-1:0] matrix_sig,
  input wire logic [run_timer_pkg::NUM_VOUT-1:0] virt_out,
  // Calendar clock
  input wire logic [run_timer_pkg::DATE_W-1:0] cal_date,
  input wire logic [4:0] cal_hour,
  input wire logic [5:0] cal_min,
  input wire logic [5:0] cal_sec,
  input wire logic [2:0] cal_weekday,
  // Non-volatile save and restore
  input wire logic power_fail,
  input wire logic restore_load,
  input wire logic [run_timer_pkg::NUM_TIMERS-1:0] restore_status,
  output logic nv_save_req,
  output logic [run_timer_pkg::NUM_TIMERS-1:0] nv_save_status,
  output logic [run_timer_pkg::NUM_TIMERS-1:0] timer_output_status
);
  import run_timer_pkg::*;

  // ****************************************
  // Second divider
  // ****************************************
  logic [SEC_CNT_W-1:0] div_q; // Cycle count within a second
  logic sec_tick_q; // One-cycle pulse per second
  wire div_end = (div_q == SEC_CNT_W'(SEC_CYCLES - 1));

  // Free-running divider, single clock domain
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q <= '0;
      sec_tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_end ? '0 : div_q + 1'b1;
      sec_tick_q <= div_end;
    end
  end

  // Packed calendar time of day
  wire [TOD_W-1:0] cal_tod = {cal_hour, cal_min, cal_sec};

  // ****************************************
  // APB decode
  // ****************************************
  logic pready_q; // Access-phase ready
  logic [DATA_W-1:0] prdata_q; // Captured read data
  logic pslverr_q; // Unmapped address
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready_q & pwrite;
  wire wr_hours = wr & (paddr == REG_HOURS);
  wire wr_secs = wr & (paddr == REG_SECS);
  wire wr_count = wr & (paddr == REG_COUNT);
  wire wr_select = wr & (paddr == REG_SELECT);
  // Timer page fields
  wire tmr_hit = (paddr[TMR_PAGE_LSB +: 2] == TMR_PAGE) && (paddr[1:0] == 2'h0);
  wire [1:0] tmr_idx = paddr[TMR_IDX_LSB +: 2];
  wire [1:0] tmr_reg = paddr[TMR_REG_LSB +: 2];
  wire wr_tmr = wr & tmr_hit;

  // ****************************************
  // Supervised signal
  // ****************************************
  logic [SEL_W-1:0] sel_q; // Chosen source code
  logic sig_q; // Run status, last sampled level
  wire [NUM_SRC-1:0] src_bus = {virt_out, matrix_sig, virt_in, phys_in};
  // None or unknown code counts nothing
  wire sel_valid = (sel_q != SEL_NONE) && (sel_q <= SEL_LAST);
  wire [SEL_W-1:0] sel_idx = sel_q - SEL_W'(1);
  wire sel_now = sel_valid & src_bus[sel_idx[SRC_IDX_W-1:0]];
  wire rise = sel_now & ~sig_q;
  wire fall = ~sel_now & sig_q;

  // Selection register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_q <= SEL_NONE;
    end
    else if (wr_select)
    begin
      sel_q <= pwdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sig_q <= 1'b0;
    end
    else
    begin
      sig_q <= sel_now;
    end
  end

  // ****************************************
  // Running time accumulator
  // ****************************************
  logic [3:0] frac_q; // Active seconds not yet added
  logic [HOURS_W-1:0] hours_q; // Whole hours
  logic [SECS_W-1:0] secs_q; // Seconds within hour
  logic [COUNT_W-1:0] count_q; // Activation count
  // Add ten seconds when step is full
  wire step = sec_tick_q & sig_q & (frac_q == RES_STEP - 4'h1);
  wire [SECS_W:0] secs_sum = {1'b0, secs_q} + {9'h000, RES_STEP};
  wire carry = secs_sum > {1'b0, SECS_MAX};
  wire [SECS_W:0] secs_wrap = secs_sum - SECS_PER_HOUR;
  wire hours_full = (hours_q >= HOURS_MAX);
  // Clamp software values to the legal range
  wire [HOURS_W-1:0] hours_wr = (pwdata[HOURS_W-1:0] > HOURS_MAX) ? HOURS_MAX : pwdata[HOURS_W-1:0];
  wire [SECS_W-1:0] secs_wr = (pwdata[SECS_W-1:0] > SECS_MAX) ? SECS_MAX : pwdata[SECS_W-1:0];

  // Sub-step second counter, only while running
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      frac_q <= 4'h0;
    end
    else if (sec_tick_q && sig_q)
    begin
      frac_q <= step ? 4'h0 : frac_q + 4'h1;
    end
  end

  // Hours; a software load wins over the carry
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hours_q <= '0;
    end
    else if (wr_hours)
    begin
      hours_q <= hours_wr;
    end
    // Saturate at the top of range
    else if (step && carry && !hours_full)
    begin
      hours_q <= hours_q + 20'h00001;
    end
  end

  // Seconds; pinned at 3599 on each carry once hours are full
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      secs_q <= '0;
    end
    else if (wr_secs)
    begin
      secs_q <= secs_wr;
    end
    else if (step)
    begin
      secs_q <= !carry ? secs_sum[SECS_W-1:0] : (hours_full ? SECS_MAX : secs_wrap[SECS_W-1:0]);
    end
  end

  // Activation counter wraps past 65535
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_q <= '0;
    end
    else if (wr_count)
    begin
      count_q <= pwdata[COUNT_W-1:0];
    end
    else if (rise)
    begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ****************************************
  // Start and stop stamps
  // ****************************************
  logic [DATE_W-1:0] start_date_q; // Date of last activation
  logic [TOD_W-1:0] start_tod_q; // Time of last activation
  logic [DATE_W-1:0] stop_date_q; // Date of last inactivation
  logic [TOD_W-1:0] stop_tod_q; // Time of last inactivation

  // Stamps take the calendar as seen at the edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_date_q <= '0;
      start_tod_q <= '0;
      stop_date_q <= '0;
      stop_tod_q <= '0;
    end
    else if (rise)
    begin
      start_date_q <= cal_date;
      start_tod_q <= cal_tod;
    end
    else if (fall)
    begin
      stop_date_q <= cal_date;
      stop_tod_q <= cal_tod;
    end
  end

  // ****************************************
  // Calendar timers
  // ****************************************
  logic [TOD_W-1:0] on_q [NUM_TIMERS]; // On time per timer
  logic [TOD_W-1:0] off_q [NUM_TIMERS]; // Off time per timer
  logic [MODE_W-1:0] mode_q [NUM_TIMERS]; // Mode per timer

  for (genvar i = 0; i < NUM_TIMERS; i++)
  begin : g_tmr
    wire sel_i = wr_tmr & (tmr_idx == 2'(i));

    // Setting registers; reset leaves the timer idle
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        on_q[i] <= '0;
        off_q[i] <= '0;
        mode_q[i] <= MODE_NONE;
      end
      // On and off time of day
      else if (sel_i && tmr_reg == TMR_ON)
      begin
        on_q[i] <= pwdata[TOD_W-1:0];
      end
      else if (sel_i && tmr_reg == TMR_OFF)
      begin
        off_q[i] <= pwdata[TOD_W-1:0];
      end
      else if (sel_i && tmr_reg == TMR_MODE)
      begin
        mode_q[i] <= pwdata[MODE_W-1:0];
      end
    end

    cal_timer u_timer (
      .clk(clk),
      .resetn(resetn),
      .sec_tick(sec_tick_q),
      .cal_tod(cal_tod),
      .weekday(cal_weekday),
      .mode(mode_q[i]),
      .on_tod(on_q[i]),
      .off_tod(off_q[i]),
      .force_we(sel_i && tmr_reg == TMR_STAT),
      .force_val(pwdata[TSTAT_OUT_BIT]),
      .restore_we(restore_load),
      .restore_val(restore_status[i]),
      .out_q(timer_output_status[i])
    );
  end

  // ****************************************
  // Non-volatile save
  // ****************************************
  logic nv_req_q; // Save request pulse
  logic [NUM_TIMERS-1:0] nv_stat_q; // Snapshot to store

  // Snapshot timer states on power loss
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nv_req_q <= 1'b0;
      nv_stat_q <= '0;
    end
    else
    begin
      nv_req_q <= power_fail;
      if (power_fail)
      begin
        nv_stat_q <= timer_output_status;
      end
    end
  end

  assign nv_save_req = nv_req_q;
  assign nv_save_status = nv_stat_q;

  // ****************************************
  // Read mux
  // ****************************************
  wire [MODE_W-1:0] rd_mode = mode_q[tmr_idx];
  wire rd_in_use = (rd_mode != MODE_NONE) && (rd_mode <= MODE_WEEKEND);
  wire [1:0] rd_tstat = {rd_in_use, timer_output_status[tmr_idx]};
  wire [DATA_W-1:0] tmr_rd =
    (tmr_reg == TMR_ON) ? DATA_W'(on_q[tmr_idx]) :
    (tmr_reg == TMR_OFF) ? DATA_W'(off_q[tmr_idx]) :
    (tmr_reg == TMR_MODE) ? DATA_W'(rd_mode) :
    DATA_W'(rd_tstat);
  wire reg_hit = tmr_hit || (paddr <= REG_STOP_TOD && paddr[1:0] == 2'h0);
  wire [DATA_W-1:0] rd_data =
    tmr_hit ? tmr_rd :
    (paddr == REG_HOURS) ? DATA_W'(hours_q) :
    (paddr == REG_SECS) ? DATA_W'(secs_q) :
    (paddr == REG_COUNT) ? DATA_W'(count_q) :
    (paddr == REG_STATUS) ? DATA_W'(sig_q) :
    (paddr == REG_SELECT) ? DATA_W'(sel_q) :
    (paddr == REG_START_DATE) ? start_date_q :
    (paddr == REG_START_TOD) ? DATA_W'(start_tod_q) :
    (paddr == REG_STOP_DATE) ? stop_date_q :
    (paddr == REG_STOP_TOD) ? DATA_W'(stop_tod_q) :
    '0;

  // ****************************************
  // APB response
  // ****************************************
  // Ready one cycle after setup, so every access has no wait state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~reg_hit;
      prdata_q <= (setup && !pwrite) ? rd_data : '0;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  tenstep_add_a: assert property (step && !carry && !wr_secs |=> secs_q == $past(secs_q) + 12'h00A)
    else $error("seconds did not advance by ten");
  hours_range_a: assert property (hours_q <= HOURS_MAX)
    else $error("hours above range");
  carry_hour_a: assert property (step && carry && !hours_full && !wr_hours |=> hours_q == $past(hours_q) + 20'h00001)
    else $error("carry did not reach hours");
  secs_range_a: assert property (secs_q <= SECS_MAX)
    else $error("seconds above range");
  start_count_a: assert property (rise && !wr_count |=> count_q == $past(count_q) + 16'h0001 && start_tod_q == $past(cal_tod))
    else $error("activation not counted or stamped");
  stop_stamp_a: assert property (fall |=> stop_tod_q == $past(cal_tod) && stop_date_q == $past(cal_date))
    else $error("inactivation not stamped");
  run_status_a: assert property (sel_now ##1 sel_now |-> sig_q)
    else $error("status not run while active");
  none_hold_a: assert property (!sel_valid && !sig_q && !wr_hours && !wr_secs |=> $stable(secs_q) && $stable(hours_q))
    else $error("accumulated with no source");
  count_write_a: assert property (wr_count |=> count_q == $past(pwdata[15:0]))
    else $error("count write not taken");
  ready_timing_a: assert property (setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");

endmodule

// File: hw/run_timer_pkg.sv
package run_timer_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  // System clock period in ns
  localparam int CLK_PERIOD_NS = 25;
  // One calendar second in ns
  localparam int SEC_PERIOD_NS = 1_000_000_000;
  // Clock cycles per second, default for the top parameter
  localparam int SEC_CYCLES_DEF = SEC_PERIOD_NS / CLK_PERIOD_NS;
  // Width of the second divider
  localparam int SEC_CNT_W = 26;
  // Accumulation step in seconds
  localparam logic [3:0] RES_STEP = 4'hA;

  // ****************************************
  // Counter ranges
  // ****************************************
  localparam int HOURS_W = 20;
  localparam int SECS_W = 12;
  localparam int COUNT_W = 16;
  // Hours saturate at 876000
  localparam logic [19:0] HOURS_MAX = 20'hD5DE0;
  // Largest seconds value, 3599
  localparam logic [11:0] SECS_MAX = 12'hE0F;
  // Seconds in one hour
  localparam logic [12:0] SECS_PER_HOUR = 13'h0E10;

  // ****************************************
  // Supervised signal selection
  // ****************************************
  localparam int SEL_W = 6;
  localparam int NUM_PHYS = 8;
  localparam int NUM_VIN = 8;
  localparam int NUM_MTX = 6;
  localparam int NUM_VOUT = 6;
  localparam int NUM_SRC = NUM_PHYS + NUM_VIN + NUM_MTX + NUM_VOUT;
  localparam int SRC_IDX_W = 5;
  localparam logic [5:0] SEL_NONE = 6'h00;
  localparam logic [5:0] SEL_LAST = 6'h1C;

  // ****************************************
  // Calendar and timers
  // ****************************************
  localparam int NUM_TIMERS = 4;
  // Time of day packed as {hour[4:0], min[5:0], sec[5:0]}
  localparam int TOD_W = 17;
  localparam int DATE_W = 32;
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_NONE = 4'h0;
  localparam logic [3:0] MODE_DAILY = 4'h1;
  localparam logic [3:0] MODE_MON = 4'h2;
  localparam logic [3:0] MODE_SUN = 4'h8;
  localparam logic [3:0] MODE_WEEKDAYS = 4'h9;
  localparam logic [3:0] MODE_MON_TO_SAT = 4'hA;
  localparam logic [3:0] MODE_WEEKEND = 4'hB;
  // Weekday codes, Monday is zero
  localparam logic [2:0] DAY_SAT = 3'h5;
  localparam logic [2:0] DAY_SUN = 3'h6;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_HOURS = 8'h00;
  localparam logic [7:0] REG_SECS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_SELECT = 8'h10;
  localparam logic [7:0] REG_START_DATE = 8'h14;
  localparam logic [7:0] REG_START_TOD = 8'h18;
  localparam logic [7:0] REG_STOP_DATE = 8'h1C;
  localparam logic [7:0] REG_STOP_TOD = 8'h20;
  // Timer block: base 0x40, 16 bytes per timer
  localparam logic [1:0] TMR_PAGE = 2'h1;
  localparam int TMR_PAGE_LSB = 6;
  localparam int TMR_IDX_LSB = 4;
  localparam int TMR_REG_LSB = 2;
  localparam logic [1:0] TMR_ON = 2'h0;
  localparam logic [1:0] TMR_OFF = 2'h1;
  localparam logic [1:0] TMR_MODE = 2'h2;
  localparam logic [1:0] TMR_STAT = 2'h3;
  // Status bit positions
  localparam int RUN_BIT = 0;
  localparam int TSTAT_OUT_BIT = 0;
  localparam int TSTAT_USE_BIT = 1;

endpackage

// File: verification/run_hour_timers_tb.sv
// Compare one value, count it, report a mismatch
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", n, e, s); end end

module run_hour_timers_tb;
  import run_timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Bench signals
  // ****************************************
  // Short second keeps the run brief
  localparam int SC = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [7:0] phys_in = 8'h00;
  // Other sources left quiet
  logic [7:0] virt_in = 8'h00;
  logic [5:0] matrix_sig = 6'h00, virt_out = 6'h00;
  logic [31:0] cal_date = 32'h0;
  logic [4:0] cal_hour = 5'h00;
  logic [5:0] cal_min = 6'h00, cal_sec = 6'h00;
  logic [2:0] cal_weekday = 3'h0;
  logic power_fail = 1'b0, restore_load = 1'b0;
  logic [3:0] restore_status = 4'h0, nv_save_status, timer_output_status;
  logic nv_save_req;
  int err_total = 0, cmp_count = 0;
  // On time 08:00:00, off time 17:30:00
  localparam logic [16:0] ON_TOD = {5'h08, 6'h00, 6'h00};
  localparam logic [16:0] OFF_TOD = {5'h11, 6'h1E, 6'h00};

  run_hour_timers #(.SEC_CYCLES(SC)) dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phys_in(phys_in), .virt_in(virt_in), .matrix_sig(matrix_sig), .virt_out(virt_out), .cal_date(cal_date),
    .cal_hour(cal_hour), .cal_min(cal_min), .cal_sec(cal_sec), .cal_weekday(cal_weekday),
    .power_fail(power_fail), .restore_load(restore_load), .restore_status(restore_status),
    .nv_save_req(nv_save_req), .nv_save_status(nv_save_status), .timer_output_status(timer_output_status));

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 10);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Hung slave ends the run
    if (n >= 10)
    begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r)
  endtask

  // Wait out n seconds plus margin, end where outputs are settled
  task automatic sec_wait(input int n);
    repeat (n * SC + 5) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic cal(input logic [16:0] t, input logic [2:0] d);
    @(posedge clk);
    {cal_hour, cal_min, cal_sec} <= t;
    cal_weekday <= d;
  endtask

  function automatic logic [7:0] tmr(input int i, input logic [1:0] r);
    return {TMR_PAGE, i[1:0], r, 2'b00};
  endfunction

  // Whether a mode switches on a given day
  function automatic logic allowed(input logic [3:0] m, input logic [2:0] d);
    case (m)
      MODE_DAILY: return 1'b1;
      MODE_WEEKDAYS: return d < DAY_SAT;
      MODE_MON_TO_SAT: return d != DAY_SUN;
      MODE_WEEKEND: return d >= DAY_SAT;
      default: return m >= MODE_MON && m <= MODE_SUN && {1'b0, d} == m - MODE_MON;
    endcase
  endfunction

  // ****************************************
  // Register rows: address, write data, readback, error
  // ****************************************
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_s;
  row_s rows [6] = '{'{REG_HOURS, 32'hD5DE1, 32'hD5DE0, 1'b0}, '{REG_SECS, 32'hFA0, 32'hE0F, 1'b0},
    '{REG_COUNT, 32'hFFFF, 32'hFFFF, 1'b0}, '{REG_SELECT, 32'h3F, 32'h3F, 1'b0},
    '{REG_STATUS, 32'h1, 32'h0, 1'b0}, '{8'h24, 32'h1, 32'h0, 1'b1}};

  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("hours_rst", REG_HOURS, 32'h0);
    foreach (rows[k])
    begin
      apb(1'b1, rows[k].a, rows[k].w, r, e);
      apb(1'b0, rows[k].a, 32'h0, r, e);
      `CHK("row_data", rows[k].r, r)
      `CHK("row_err", rows[k].e, e)
    end
    // Count at 65535 wraps on the next rise; seconds carry into hours
    wr(REG_HOURS, 32'h5);
    wr(REG_SECS, 32'hE06);
    wr(REG_SELECT, 32'h1);
    cal_date <= 32'hA5A5;
    phys_in <= 8'h01;
    sec_wait(10);
    rd_chk("run", REG_STATUS, 32'h1);
    rd_chk("count", REG_COUNT, 32'h0);
    rd_chk("hours", REG_HOURS, 32'h6);
    rd_chk("secs", REG_SECS, 32'h0);
    rd_chk("start", REG_START_DATE, 32'hA5A5);
    cal_date <= 32'h5A5A;
    cal(OFF_TOD, 3'h2);
    phys_in <= 8'h00;
    rd_chk("stop", REG_STOP_DATE, 32'h5A5A);
    rd_chk("stop_tod", REG_STOP_TOD, {15'h0, OFF_TOD});
    rd_chk("idle", REG_STATUS, 32'h0);
    // No signal chosen: nothing counts
    wr(REG_SELECT, 32'h0);
    phys_in <= 8'h01;
    sec_wait(10);
    rd_chk("none_cnt", REG_COUNT, 32'h0);
    rd_chk("none_secs", REG_SECS, 32'h0);
    // Every timer gets its own times
    for (int i = 0; i < 4; i++)
    begin
      wr(tmr(i, TMR_ON), {15'h0, ON_TOD});
      wr(tmr(i, TMR_OFF), {15'h0, OFF_TOD});
    end
    rd_chk("on_tod", tmr(3, TMR_ON), {15'h0, ON_TOD});
    // Every mode on every weekday, timer 0 only
    for (int m = 0; m < 12; m++)
      for (int d = 0; d < 7; d++)
      begin
        cal(17'h0, d[2:0]);
        wr(tmr(0, TMR_STAT), 32'h0);
        wr(tmr(0, TMR_MODE), m);
        cal(ON_TOD, d[2:0]);
        sec_wait(1);
        `CHK("mode", {3'h0, allowed(m[3:0], d[2:0])}, timer_output_status)
      end
    // Force on from a known low, held until the scheduled off act
    cal(17'h1, 3'h0);
    wr(tmr(0, TMR_STAT), 32'h0);
    wr(tmr(0, TMR_MODE), {28'h0, MODE_DAILY});
    wr(tmr(0, TMR_STAT), 32'h1);
    sec_wait(2);
    `CHK("forced", 4'h1, timer_output_status)
    rd_chk("tstat", tmr(0, TMR_STAT), 32'h3);
    cal(OFF_TOD, 3'h0);
    sec_wait(1);
    `CHK("force_end", 4'h0, timer_output_status)
    // Idle timer ignores a status write
    wr(tmr(1, TMR_STAT), 32'h1);
    @(negedge clk);
    `CHK("idle_tmr", 4'h0, timer_output_status)
    // Power loss snapshot, then restore; leave the off time first
    cal(17'h1, 3'h0);
    wr(tmr(0, TMR_STAT), 32'h1);
    @(posedge clk);
    power_fail <= 1'b1;
    @(posedge clk);
    power_fail <= 1'b0;
    @(negedge clk);
    `CHK("save_req", 1'b1, nv_save_req)
    `CHK("save", 4'h1, nv_save_status)
    wr(tmr(0, TMR_STAT), 32'h0);
    @(posedge clk);
    restore_status <= 4'hF;
    restore_load <= 1'b1;
    @(posedge clk);
    restore_load <= 1'b0;
    @(negedge clk);
    `CHK("restore", 4'h1, timer_output_status)
    // Timer 2 switches on its own schedule
    wr(tmr(2, TMR_MODE), {28'h0, MODE_DAILY});
    cal(ON_TOD, 3'h3);
    sec_wait(1);
    `CHK("tmr_pair", 4'h5, timer_output_status)
    end_sim();
  end
endmodule
